// ---- clock_path_map.vh ----
// register offsets, field positions, reset values and code points of the clock path configuration block
// assumes a simple byte-wide register port with word addresses up to 10 bits
`ifndef CLOCK_PATH_MAP_VH
`define CLOCK_PATH_MAP_VH

`define ADDR_PLL_MODE_POLARITY_CTRL 10'h010
`define ADDR_VCO_CALIBRATION_CTRL 10'h018
`define ADDR_REFERENCE_INPUT_ENABLE 10'h01c
`define ADDR_VCO_DIVIDER_RATIO 10'h1e0
`define ADDR_SOURCE_PATH_SELECT 10'h1e1
`define ADDR_REGISTER_TRANSFER_STROBE 10'h232

`define PLL_POWER_LSB 0
`define PLL_POWER_MSB 1
`define PFD_POLARITY_BIT 7
`define VCO_CAL_BIT 0
`define REF_ENABLE_MSB 2
`define VCO_DIV_MSB 2
`define DIV_BYPASS_BIT 0
`define SOURCE_VCO_BIT 1
`define TRANSFER_BIT 0

`define PLL_POWER_NORMAL 2'h0
`define PLL_POWER_DOWN 2'h1

`define RESET_PLL_MODE 8'h01
`define RESET_VCO_CAL 8'h00
`define RESET_REF_ENABLE 8'h00
`define RESET_VCO_DIV 8'h00
`define RESET_SOURCE_PATH 8'h00

`define NV_IMAGE_WIDTH 40

`endif

// ---- nv_config_store.v ----
// on-board nonvolatile image of the five configuration bytes
// assumes a save strobe from the register block; holds contents across a reset
`timescale 1ns/1ps
`include "clock_path_map.vh"

module nv_config_store #(
    parameter WIDTH = `NV_IMAGE_WIDTH
) (
    input wire clk,
    input wire clkEn,
    input wire saveStrobe,
    input wire [WIDTH-1:0] saveData,
    input wire nvPresetValid,
    input wire [WIDTH-1:0] nvPresetData,
    output reg imageValid,
    output reg [WIDTH-1:0] imageData
);

    // no reset here: a stored image must survive chip reset, like real nonvolatile cells
    always @(posedge clk) begin
        if (clkEn) begin
            if (saveStrobe) begin
                imageData <= saveData;
                imageValid <= 1'b1;
            end else if (nvPresetValid && !imageValid) begin
                imageData <= nvPresetData;
                imageValid <= 1'b1;
            end
        end
    end

    initial begin
        imageValid = 1'b0;
        imageData = {WIDTH{1'b0}};
    end

endmodule

// ---- clock_path_mode_config.v ----
// clock path mode configuration: shadow and active registers, transfer strobe, source routing and calibration start
// assumes a byte-wide register port on clk; controller follows the calibration and bypass limits itself
//
// Behaviour
// - pll power field 00 runs pll, 01 powers it down, both registered on clk
// - source bit 1 selects internal vco, 0 selects external clk input
// - bypass bit 0 routes through vco divider, 1 routes around it
// - polarity bit 0 is positive, 1 is negative phase detector polarity
// - three-bit vco divider ratios 1 to 6; code 000 gives divide-by-2
// - reset defaults: pll down, clk source, divider in path, divider field zero
// - pll with external vco powers internal vco off, feeds prescaler directly
// - configuration can be saved nonvolatile and restored at power-up
`timescale 1ns/1ps
`include "clock_path_map.vh"

module clock_path_mode_config #(
    parameter ADDR_WIDTH = 10
) (
    input wire clk,
    input wire nrst,
    input wire clkEn,
    input wire regWrite,
    input wire regRead,
    input wire [ADDR_WIDTH-1:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    input wire nvSave,
    input wire nvPresetValid,
    input wire [`NV_IMAGE_WIDTH-1:0] nvPresetData,
    output reg pllPowerDown,
    output reg pllRunning,
    output reg pfdNegative,
    output reg sourceIsVco,
    output reg dividerBypass,
    output reg [2:0] vcoDivideRatio,
    output reg [2:0] refInputEnable,
    output reg internalVcoPowered,
    output reg prescalerFromClk,
    output reg calibrationStart,
    output reg calibrationArmed
);

    localparam ST_LOAD = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_IDLE = 3'h4;

    // shadow copies written by software
    reg [7:0] shPll;
    reg [7:0] shCal;
    reg [7:0] shRef;
    reg [7:0] shDiv;
    reg [7:0] shSrc;
    // active copies steering the clock path
    reg [7:0] actPll;
    reg [7:0] actCal;
    reg [7:0] actRef;
    reg [7:0] actDiv;
    reg [7:0] actSrc;
    reg [2:0] state;
    reg [2:0] next_state;
    reg transferPending;
    wire nvValid;
    wire [`NV_IMAGE_WIDTH-1:0] nvImage;
    wire [`NV_IMAGE_WIDTH-1:0] liveImage;
    wire doTransfer;

    // divider code to ratio: 000 means divide-by-2, 111 gives 6, others their own value
    function [2:0] div_ratio;
        input [2:0] code;
        begin
            if (code == 3'h0) begin
                div_ratio = 3'h2;
            end else if (code > 3'h6) begin
                div_ratio = 3'h6;
            end else begin
                div_ratio = code;
            end
        end
    endfunction

    // pll field decode, shared by every output that depends on the pll running
    function pll_normal;
        input [7:0] pllReg;
        begin
            pll_normal = pllReg[`PLL_POWER_MSB:`PLL_POWER_LSB] == `PLL_POWER_NORMAL;
        end
    endfunction

    assign liveImage = {actPll, actCal, actRef, actDiv, actSrc};
    assign doTransfer = regWrite && (regAddr == `ADDR_REGISTER_TRANSFER_STROBE) &&
        regWdata[`TRANSFER_BIT];

    nv_config_store #(
        .WIDTH(`NV_IMAGE_WIDTH)
    ) nvStore (
        .clk(clk),
        .clkEn(clkEn),
        .saveStrobe(nvSave && state == ST_IDLE),
        .saveData(liveImage),
        .nvPresetValid(nvPresetValid),
        .nvPresetData(nvPresetData),
        .imageValid(nvValid),
        .imageData(nvImage)
    );

    // after reset, one load cycle pulls in the saved image before software runs
    always @* begin
        case (state)
            ST_LOAD: next_state = ST_IDLE;
            ST_IDLE: next_state = ST_IDLE;
            ST_RUN: next_state = ST_IDLE;
            default: next_state = ST_LOAD;
        endcase
    end

    // register file: shadow writes, transfer, nonvolatile restore
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_LOAD;
            shPll <= `RESET_PLL_MODE;
            shCal <= `RESET_VCO_CAL;
            shRef <= `RESET_REF_ENABLE;
            shDiv <= `RESET_VCO_DIV;
            shSrc <= `RESET_SOURCE_PATH;
            actPll <= `RESET_PLL_MODE;
            actCal <= `RESET_VCO_CAL;
            actRef <= `RESET_REF_ENABLE;
            actDiv <= `RESET_VCO_DIV;
            actSrc <= `RESET_SOURCE_PATH;
            transferPending <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            transferPending <= 1'b0;
            if (state == ST_LOAD && nvValid) begin
                // restore saved configuration without controller action
                {shPll, shCal, shRef, shDiv, shSrc} <= nvImage;
                {actPll, actCal, actRef, actDiv, actSrc} <= nvImage;
            end else begin
                if (regWrite) begin
                    case (regAddr)
                        `ADDR_PLL_MODE_POLARITY_CTRL: shPll <= regWdata;
                        `ADDR_VCO_CALIBRATION_CTRL: shCal <= regWdata;
                        `ADDR_REFERENCE_INPUT_ENABLE: shRef <= regWdata;
                        `ADDR_VCO_DIVIDER_RATIO: shDiv <= regWdata;
                        `ADDR_SOURCE_PATH_SELECT: shSrc <= regWdata;
                        default: ;
                    endcase
                end
                if (doTransfer) begin
                    transferPending <= 1'b1;
                end
                // apply shadow on the cycle after the strobe write so same-cycle shadow writes land first
                if (transferPending) begin
                    actPll <= shPll;
                    actCal <= shCal;
                    actRef <= shRef;
                    actDiv <= shDiv;
                    actSrc <= shSrc;
                end
            end
        end
    end

    // calibration starts on a transfer that moves the calibrate bit from 0 to 1
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            calibrationStart <= 1'b0;
            calibrationArmed <= 1'b0;
        end else if (clkEn) begin
            calibrationStart <= transferPending && shCal[`VCO_CAL_BIT] &&
                !actCal[`VCO_CAL_BIT];
            calibrationArmed <= transferPending ? shCal[`VCO_CAL_BIT] : actCal[`VCO_CAL_BIT];
        end
    end

    // pll power state; codes other than 00 and 01 count as power-down, the safe side
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pllPowerDown <= 1'b1;
            pllRunning <= 1'b0;
        end else if (clkEn) begin
            pllRunning <= pll_normal(actPll);
            pllPowerDown <= !pll_normal(actPll);
        end
    end

    // phase detector polarity, only meaningful with an external oscillator
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pfdNegative <= 1'b0;
        end else if (clkEn) begin
            pfdNegative <= actPll[`PFD_POLARITY_BIT];
        end
    end

    // source and divider routing
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sourceIsVco <= 1'b0;
            dividerBypass <= 1'b0;
        end else if (clkEn) begin
            sourceIsVco <= actSrc[`SOURCE_VCO_BIT];
            dividerBypass <= actSrc[`DIV_BYPASS_BIT];
        end
    end

    // effective divider ratio; reset shows divide-by-2 like code 000
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vcoDivideRatio <= 3'h2;
        end else if (clkEn) begin
            vcoDivideRatio <= div_ratio(actDiv[`VCO_DIV_MSB:0]);
        end
    end

    // reference input enables pass straight from the active copy
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            refInputEnable <= 3'h0;
        end else if (clkEn) begin
            refInputEnable <= actRef[`REF_ENABLE_MSB:0];
        end
    end

    // internal vco only powered when it is the source and pll runs
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            internalVcoPowered <= 1'b0;
            prescalerFromClk <= 1'b0;
        end else if (clkEn) begin
            internalVcoPowered <= actSrc[`SOURCE_VCO_BIT] && pll_normal(actPll);
            prescalerFromClk <= !actSrc[`SOURCE_VCO_BIT] && pll_normal(actPll);
        end
    end

    // read data shows shadow values; strobe reads back the pending flag, set only in the cycle after the strobe write
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else if (clkEn && regRead) begin
            case (regAddr)
                `ADDR_PLL_MODE_POLARITY_CTRL: regRdata <= shPll;
                `ADDR_VCO_CALIBRATION_CTRL: regRdata <= shCal;
                `ADDR_REFERENCE_INPUT_ENABLE: regRdata <= shRef;
                `ADDR_VCO_DIVIDER_RATIO: regRdata <= shDiv;
                `ADDR_SOURCE_PATH_SELECT: regRdata <= shSrc;
                `ADDR_REGISTER_TRANSFER_STROBE: regRdata <= {7'h00, transferPending};
                default: regRdata <= 8'h00;
            endcase
        end
    end

endmodule

// ---- preset_image_source.sv ----
// factory preset image source standing at the nonvolatile preset port
// assumes the bench raises present only while a preset should exist
`timescale 1ns/1ps
module preset_image_source #(
    parameter logic [39:0] IMAGE = 40'h0100000000
) (
    input wire logic present,
    output wire logic nvPresetValid,
    output wire logic [39:0] nvPresetData
);
    // an absent image shows a fixed alternating-bit pattern, never a stale copy
    assign nvPresetValid = present;
    assign nvPresetData = present ? IMAGE : 40'haaaaaaaaaa;
endmodule

// ---- clock_path_mode_config_checker.sv ----
// port-level checker for the clock path configuration block
// assumes clkEn is held high by the bench
`timescale 1ns/1ps
module clock_path_mode_config_checker #(
    parameter ADDR_WIDTH = 10
) (
    input wire clk,
    input wire nrst,
    input wire regWrite,
    input wire [ADDR_WIDTH-1:0] regAddr,
    input wire [7:0] regWdata,
    input wire pllPowerDown,
    input wire pllRunning,
    input wire pfdNegative,
    input wire sourceIsVco,
    input wire dividerBypass,
    input wire [2:0] vcoDivideRatio,
    input wire internalVcoPowered,
    input wire prescalerFromClk,
    input wire calibrationStart
);
    reg [2:0] age;
    wire strobe = regWrite && regAddr == 'h232 && regWdata[0];
    // settle counter, so the load cycle after reset is not taken for a transfer
    always @(posedge clk or negedge nrst) begin
        if (!nrst) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    chk_run_exclusive: assert property (@(posedge clk) disable iff (!nrst) pllRunning != pllPowerDown)
        else $error("pll run and power-down agree");
    chk_reset_defaults: assert property (@(posedge clk) !nrst |-> pllPowerDown && vcoDivideRatio == 3'h2)
        else $error("reset outputs wrong");
    chk_ratio_range: assert property (@(posedge clk) disable iff (!nrst) vcoDivideRatio inside {[1:6]})
        else $error("divide ratio out of range");
    chk_vco_power: assert property (@(posedge clk) disable iff (!nrst)
        internalVcoPowered == (sourceIsVco && pllRunning)) else $error("vco power wrong");
    chk_prescaler_feed: assert property (@(posedge clk) disable iff (!nrst)
        prescalerFromClk == (!sourceIsVco && pllRunning)) else $error("prescaler feed wrong");
    chk_cal_single: assert property (@(posedge clk) disable iff (!nrst) calibrationStart |=> !calibrationStart)
        else $error("calibration pulse too long");
    chk_cal_cause: assert property (@(posedge clk) disable iff (!nrst) calibrationStart |-> $past(strobe, 2))
        else $error("calibration without strobe");
    chk_cfg_transfer: assert property (@(posedge clk) disable iff (!nrst) age == 3'h7 &&
        ($changed(sourceIsVco) || $changed(dividerBypass) || $changed(pfdNegative)) |-> $past(strobe, 3))
        else $error("config changed without strobe");
endmodule
bind clock_path_mode_config clock_path_mode_config_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_checker (.clk(clk),
    .nrst(nrst), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .pllPowerDown(pllPowerDown),
    .pllRunning(pllRunning), .pfdNegative(pfdNegative), .sourceIsVco(sourceIsVco), .dividerBypass(dividerBypass),
    .vcoDivideRatio(vcoDivideRatio), .internalVcoPowered(internalVcoPowered), .prescalerFromClk(prescalerFromClk),
    .calibrationStart(calibrationStart));

// ---- test_clock_path_mode_config.sv ----
// self-checking bench for the clock path configuration block
// assumes the preset source model and the checker bind are compiled first
`timescale 1ns/1ps
module test_clock_path_mode_config;
    localparam logic [39:0] PRESET = 40'h8007030501;
    logic clk, nrst, regWrite, regRead, nvSave, presetOn;
    logic [9:0] regAddr;
    logic [7:0] regWdata;
    wire [7:0] regRdata;
    wire nvPresetValid, pllPowerDown, pllRunning, pfdNegative, sourceIsVco, dividerBypass;
    wire internalVcoPowered, prescalerFromClk, calibrationStart, calibrationArmed;
    wire [2:0] vcoDivideRatio, refInputEnable;
    wire [39:0] nvPresetData;
    wire [13:0] got = {pllPowerDown, pllRunning, pfdNegative, sourceIsVco, dividerBypass, vcoDivideRatio,
        refInputEnable, internalVcoPowered, prescalerFromClk, calibrationArmed};
    logic [7:0] s [5];
    logic [7:0] a [5];
    logic [9:0] adr [5] = '{10'h010, 10'h018, 10'h01c, 10'h1e0, 10'h1e1};
    logic [31:0] seed = 32'hc2af;
    int err_total, compares, calCount, calExp;
    clock_path_mode_config i_dut (.clk(clk), .nrst(nrst), .clkEn(1'b1), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .nvSave(nvSave),
        .nvPresetValid(nvPresetValid), .nvPresetData(nvPresetData), .pllPowerDown(pllPowerDown),
        .pllRunning(pllRunning), .pfdNegative(pfdNegative), .sourceIsVco(sourceIsVco),
        .dividerBypass(dividerBypass), .vcoDivideRatio(vcoDivideRatio), .refInputEnable(refInputEnable),
        .internalVcoPowered(internalVcoPowered), .prescalerFromClk(prescalerFromClk),
        .calibrationStart(calibrationStart), .calibrationArmed(calibrationArmed));
    preset_image_source #(.IMAGE(PRESET)) i_preset (.present(presetOn), .nvPresetValid(nvPresetValid),
        .nvPresetData(nvPresetData));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // pulses stand one cycle, so count them as they pass
    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        if (calibrationStart === 1'b1) calCount++;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // expected outputs from the active copy; codes 10/11 count as powered down
    function automatic logic [13:0] expOut();
        logic run;
        logic [2:0] d;
        run = a[0][1:0] == 2'h0;
        d = a[3][2:0];
        return {!run, run, a[0][7], a[4][1], a[4][0], (d == 3'h0) ? 3'h2 : (d == 3'h7) ? 3'h6 : d,
            a[2][2:0], a[4][1] && run, !a[4][1] && run, a[1][0]};
    endfunction
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] ad, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= ad;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] ad, input logic [7:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= ad;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        #1 check(regRdata, e);
    endtask
    task automatic xfer();
        calExp += (s[1][0] && !a[1][0]) ? 1 : 0;
        a = s;
        wr(10'h232, 8'h01);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic doReset(input logic [39:0] img);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) s[i] = img[39 - 8 * i -: 8];
        a = s;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic run(input int n);
        repeat (n) begin
            for (int i = 0; i < 5; i++) begin
                s[i] = rnd();
                wr(adr[i], s[i]);
            end
            #1 check(got, expOut());
            for (int i = 0; i < 5; i++) rd(adr[i], s[i]);
            xfer();
            check(got, expOut());
            check(calCount[15:0], calExp[15:0]);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        {regWrite, regRead, nvSave, presetOn, nrst} = 5'h01;
        regAddr = 10'h000;
        regWdata = 8'h00;
        #1 nrst = 1'b0;
        doReset(40'h0100000000);
        check(got, expOut());
        for (int i = 0; i < 5; i++) rd(adr[i], s[i]);
        run(6);
        for (int d = 0; d < 8; d++) begin
            s[3] = d[7:0];
            wr(10'h1e0, s[3]);
            xfer();
            check(got, expOut());
        end
        // external oscillator on clk below the divider limit: pll on, clk source, bypass
        s[0] = 8'h00;
        s[2] = 8'h01;
        s[4] = 8'h01;
        for (int i = 0; i < 5; i++) wr(adr[i], s[i]);
        xfer();
        check(got, expOut());
        // internal vco, divider in path: clear-and-strobe, then set-and-strobe
        s[4] = 8'h02;
        s[1] = 8'h00;
        wr(10'h1e1, s[4]);
        wr(10'h018, s[1]);
        xfer();
        s[1] = 8'h01;
        wr(10'h018, s[1]);
        xfer();
        check(got, expOut());
        check(calCount[15:0], calExp[15:0]);
        wr(10'h3ff, 8'hff);
        rd(10'h3ff, 8'h00);
        rd(10'h232, 8'h00);
        presetOn <= 1'b1;
        doReset(PRESET);
        check(got, expOut());
        run(6);
        @(posedge clk) nvSave <= 1'b1;
        @(posedge clk) nvSave <= 1'b0;
        doReset({a[0], a[1], a[2], a[3], a[4]});
        check(got, expOut());
        tally_and_finish();
    end
endmodule
